/* File: logic/irq_ctrl_map.vh */
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH
// Register indices; byte address is four times the index
`define IDX_ENABLE      8'ha8
`define IDX_PRIO_HIGH   8'hb7
`define IDX_PRIO_LOW    8'hb8
`define IDX_AUX_CTRL    8'hc0
`define IDX_ISR_CTRL    8'hd0
`define IDX_ISR_STATUS  8'hd4
// Enable register fields
`define EN_GLOBAL       7
// Auxiliary control fields
`define AUX_EXT2_TRIG   0
`define AUX_EXT2_PEND   1
`define AUX_EXT2_EN     2
`define AUX_EXT2_PLOW   3
`define AUX_EXT3_TRIG   4
`define AUX_EXT3_PEND   5
`define AUX_EXT3_EN     6
`define AUX_EXT3_PLOW   7
// Service control register fields
`define ISR_CTRL_RETURN 0
// Reset values
`define RST_ENABLE      8'h00
`define RST_PRIO_HIGH   8'h00
`define RST_PRIO_LOW    8'h00
`define RST_AUX_CTRL    8'h00
// Vector base and stride
`define VEC_BASE        16'h0003
`define VEC_STEP        4'h8
`endif

/* File: logic/priority_interrupt_controller.v */
// Summary of operation
// - Global enable clear blocks every interrupt
// - Each source needs its own enable
// - Enable bit 5 gates timer 2
// - Enable bit 4 gates the uart
// - Bits 3 and 1 gate timers 1, 0
// - Bits 2 and 0 gate externals 1, 0
// - Aux bit 6 enables external 3
// - Aux bit 2 enables external 2
// - External 3 pending set, cleared on vector
// - External 2 pending set, cleared on vector
// - Aux bit 4: ext3 level or falling edge
// - Aux bit 0: ext2 level or falling edge
// - Level is high bit then low bit
// - High register holds upper priority bits
// - Low register holds six lower bits
// - Ext3, ext2 lower bits in aux 7, 3
// - Preempt only by strictly higher level
// - Equal levels resolved by fixed poll order
// - Vectors 0003h to 003bh step eight
// - Hardware clears ext flag only if edge
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_map.vh"
module priority_interrupt_controller
(
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Request flags from peripherals
  input  wire        ext0_flag_i,
  input  wire        timer0_flag_i,
  input  wire        ext1_flag_i,
  input  wire        timer1_flag_i,
  input  wire        uart_flag_i,
  input  wire        timer2_flag_i,
  // External pins, active low
  input  wire        ext2_pin_n_i,
  input  wire        ext3_pin_n_i,
  // Core handshake
  input  wire        vector_ack_i,
  input  wire        isr_return_i,
  output reg         irq_req_o,
  output reg  [2:0]  irq_index_o,
  output reg  [1:0]  irq_level_o,
  output reg  [15:0] irq_vector_o,
  output reg  [7:0]  irq_taken_o
);

  reg  [7:0] irq_enable_reg;
  reg  [7:0] irq_prio_high_reg;
  reg  [7:0] irq_prio_low_reg;
  reg  [7:0] aux_ext_irq_ctrl_reg;
  reg  [3:0] in_service;

  // Enable bits by name
  wire global_irq_enable = irq_enable_reg[`EN_GLOBAL];
  wire timer2_irq_enable = irq_enable_reg[5];
  wire uart_irq_enable   = irq_enable_reg[4];
  wire timer1_irq_enable = irq_enable_reg[3];
  wire ext1_irq_enable   = irq_enable_reg[2];
  wire timer0_irq_enable = irq_enable_reg[1];
  wire ext0_irq_enable   = irq_enable_reg[0];
  wire ext3_irq_enable   = aux_ext_irq_ctrl_reg[`AUX_EXT3_EN];
  wire ext2_irq_enable   = aux_ext_irq_ctrl_reg[`AUX_EXT2_EN];

  // Auxiliary control fields
  wire ext2_trigger_sel  = aux_ext_irq_ctrl_reg[`AUX_EXT2_TRIG];
  wire ext3_trigger_sel  = aux_ext_irq_ctrl_reg[`AUX_EXT3_TRIG];
  wire ext2_pending_flag = aux_ext_irq_ctrl_reg[`AUX_EXT2_PEND];
  wire ext3_pending_flag = aux_ext_irq_ctrl_reg[`AUX_EXT3_PEND];

  // Per-source enables in poll order
  wire [7:0] src_en;
  assign src_en[0] = ext0_irq_enable;
  assign src_en[1] = timer0_irq_enable;
  assign src_en[2] = ext1_irq_enable;
  assign src_en[3] = timer1_irq_enable;
  assign src_en[4] = uart_irq_enable;
  assign src_en[5] = timer2_irq_enable;
  assign src_en[6] = ext2_irq_enable;
  assign src_en[7] = ext3_irq_enable;

  wire [7:0] src_pend = {ext3_pending_flag, ext2_pending_flag,
                         timer2_flag_i, uart_flag_i, timer1_flag_i,
                         ext1_flag_i, timer0_flag_i, ext0_flag_i};

  // Upper priority bits
  wire ext3_prio_high   = irq_prio_high_reg[7];
  wire ext2_prio_high   = irq_prio_high_reg[6];
  wire timer2_prio_high = irq_prio_high_reg[5];
  wire uart_prio_high   = irq_prio_high_reg[4];
  wire timer1_prio_high = irq_prio_high_reg[3];
  wire ext1_prio_high   = irq_prio_high_reg[2];
  wire timer0_prio_high = irq_prio_high_reg[1];
  wire ext0_prio_high   = irq_prio_high_reg[0];

  // Lower priority bits: ext2/ext3 live in the aux register
  wire ext3_prio_low    = aux_ext_irq_ctrl_reg[`AUX_EXT3_PLOW];
  wire ext2_prio_low    = aux_ext_irq_ctrl_reg[`AUX_EXT2_PLOW];
  wire timer2_prio_low  = irq_prio_low_reg[5];
  wire uart_prio_low    = irq_prio_low_reg[4];
  wire timer1_prio_low  = irq_prio_low_reg[3];
  wire ext1_prio_low    = irq_prio_low_reg[2];
  wire timer0_prio_low  = irq_prio_low_reg[1];
  wire ext0_prio_low    = irq_prio_low_reg[0];

  // Gathered in poll order
  wire [7:0] prio_high = {ext3_prio_high, ext2_prio_high, timer2_prio_high,
                          uart_prio_high, timer1_prio_high, ext1_prio_high,
                          timer0_prio_high, ext0_prio_high};
  wire [7:0] prio_low  = {ext3_prio_low, ext2_prio_low, timer2_prio_low,
                          uart_prio_low, timer1_prio_low, ext1_prio_low,
                          timer0_prio_low, ext0_prio_low};

  // Two-bit level per source, high bit upper
  wire [15:0] src_lvl;
  genvar      g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_lvl
      assign src_lvl[2*g+1:2*g] = {prio_high[g], prio_low[g]};
    end
  endgenerate

  wire [7:0] active = src_pend & src_en
                      & {8{global_irq_enable}};

  // Highest level of the routines now in service, or none
  reg        busy;
  reg  [1:0] busy_lvl;
  // Winner search
  reg        found;
  reg  [2:0] win_idx;
  reg  [1:0] win_lvl;
  reg  [1:0] lvl;
  integer    i;

  always @*
  begin
    busy     = |in_service;
    busy_lvl = 2'd0;
    for (i = 0; i < 4; i = i + 1)
      if (in_service[i])
        busy_lvl = i[1:0];
    found   = 1'b0;
    win_idx = 3'd0;
    win_lvl = 2'd0;
    // Scan from last in poll order so earlier sources win ties
    for (i = 7; i >= 0; i = i - 1)
    begin
      lvl = src_lvl[2*i +: 2];
      if (active[i] && (!found || lvl >= win_lvl))
      begin
        found   = 1'b1;
        win_idx = i[2:0];
        win_lvl = lvl;
      end
    end
  end

  // Strictly higher than any routine already running
  wire grant_ok = found && (!busy || win_lvl > busy_lvl);

  wire vector_taken = vector_ack_i && irq_req_o;

  // Wishbone decode, word index from byte address
  wire [7:0] word_idx = adr_i[9:2];
  wire       bus_req  = cyc_i && stb_i && !ack_o;
  wire       wr_lane  = bus_req && we_i && sel_i[0];

  wire       aux_wr   = wr_lane && word_idx == `IDX_AUX_CTRL;
  // Trigger modes as they will stand after this cycle's write
  wire ext2_edge_next = aux_wr ? dat_i[`AUX_EXT2_TRIG] : ext2_trigger_sel;
  wire ext3_edge_next = aux_wr ? dat_i[`AUX_EXT3_TRIG] : ext3_trigger_sel;
  // Hardware clear on vectoring, edge mode only
  wire ext2_vec_clr = vector_taken && irq_index_o == 3'h6
                      && ext2_trigger_sel;
  wire ext3_vec_clr = vector_taken && irq_index_o == 3'h7
                      && ext3_trigger_sel;
  wire ext2_next_flag;
  wire ext3_next_flag;

  ext_trigger #(.IDLE_LEVEL(1'b1)) ext2_trig
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .pin_n_i     (ext2_pin_n_i),
    .edge_mode_i (ext2_edge_next),
    .flag_i      (ext2_pending_flag),
    .sw_write_i  (aux_wr),
    .sw_value_i  (dat_i[`AUX_EXT2_PEND]),
    .hw_clear_i  (ext2_vec_clr),
    .next_flag_o (ext2_next_flag)
  );

  ext_trigger #(.IDLE_LEVEL(1'b1)) ext3_trig
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .pin_n_i     (ext3_pin_n_i),
    .edge_mode_i (ext3_edge_next),
    .flag_i      (ext3_pending_flag),
    .sw_write_i  (aux_wr),
    .sw_value_i  (dat_i[`AUX_EXT3_PEND]),
    .hw_clear_i  (ext3_vec_clr),
    .next_flag_o (ext3_next_flag)
  );

  reg [7:0] next_aux;
  always @*
  begin
    next_aux = aux_ext_irq_ctrl_reg;
    if (aux_wr)
      next_aux = dat_i[7:0];
    next_aux[`AUX_EXT2_PEND] = ext2_next_flag;
    next_aux[`AUX_EXT3_PEND] = ext3_next_flag;
  end

  reg [31:0] next_dat;
  always @*
  begin
    next_dat = 32'h0000_0000;
    case (word_idx)
      `IDX_ENABLE:     next_dat[7:0] = irq_enable_reg;
      `IDX_PRIO_HIGH:  next_dat[7:0] = irq_prio_high_reg;
      `IDX_PRIO_LOW:   next_dat[7:0] = irq_prio_low_reg;
      `IDX_AUX_CTRL:   next_dat[7:0] = aux_ext_irq_ctrl_reg;
      `IDX_ISR_STATUS: next_dat[7:0] = {irq_req_o, irq_level_o,
                                        irq_index_o, busy_lvl};
      `IDX_ISR_CTRL:   next_dat[3:0] = in_service;
      default:         next_dat = 32'h0000_0000;
    endcase
  end

  // Software return retires the highest running level
  wire sw_return = wr_lane && word_idx == `IDX_ISR_CTRL
                   && dat_i[`ISR_CTRL_RETURN];
  wire do_return = isr_return_i || sw_return;

  reg [3:0] next_service;
  always @*
  begin
    next_service = in_service;
    if (do_return && busy)
      next_service[busy_lvl] = 1'b0;
    if (vector_taken)
      next_service[irq_level_o] = 1'b1;
  end

  // Next values of the core-side outputs
  wire        next_req    = grant_ok && !vector_taken;
  wire [7:0]  next_taken  = vector_taken ? (8'h01 << irq_index_o)
                                         : 8'h00;
  wire [15:0] next_vector = `VEC_BASE
                            + {10'h000, win_idx, 3'h0};

  // One write select per register word
  wire sel_enable    = wr_lane && word_idx == `IDX_ENABLE;
  wire sel_prio_high = wr_lane && word_idx == `IDX_PRIO_HIGH;
  wire sel_prio_low  = wr_lane && word_idx == `IDX_PRIO_LOW;

  // Configuration registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_enable_reg       <= `RST_ENABLE;
      irq_prio_high_reg    <= `RST_PRIO_HIGH;
      irq_prio_low_reg     <= `RST_PRIO_LOW;
      aux_ext_irq_ctrl_reg <= `RST_AUX_CTRL;
    end
    else if (ce_i)
    begin
      // Enable bit 6 and low priority bits 7:6 do not exist
      if (sel_enable)
        irq_enable_reg <= dat_i[7:0] & 8'hbf;
      if (sel_prio_high)
        irq_prio_high_reg <= dat_i[7:0];
      if (sel_prio_low)
        irq_prio_low_reg <= dat_i[7:0] & 8'h3f;
      aux_ext_irq_ctrl_reg <= next_aux;
    end
  end

  // Levels in service
  always @(posedge clk_i)
  begin
    if (rst_i)
      in_service <= 4'h0;
    else if (ce_i)
      in_service <= next_service;
  end

  // Bus answer, one cycle after the request is taken
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_o <= bus_req;
      if (bus_req)
        dat_o <= next_dat;
    end
  end

  // Core-side outputs, all registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_req_o    <= 1'b0;
      irq_index_o  <= 3'h0;
      irq_level_o  <= 2'h0;
      irq_vector_o <= 16'h0000;
      irq_taken_o  <= 8'h00;
    end
    else if (ce_i)
    begin
      // Request drops for a cycle after each vector so it re-arbitrates
      irq_req_o    <= next_req;
      irq_index_o  <= win_idx;
      irq_level_o  <= win_lvl;
      irq_vector_o <= next_vector;
      irq_taken_o  <= next_taken;
    end
  end

endmodule

// Pending flag of one auxiliary pin, falling-edge or active-low level
module ext_trigger
#(
  parameter [0:0] IDLE_LEVEL = 1'b1
)
(
  // Clock, reset, enable
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  // Pin and controls
  input  wire pin_n_i,
  input  wire edge_mode_i,
  input  wire flag_i,
  input  wire sw_write_i,
  input  wire sw_value_i,
  input  wire hw_clear_i,
  // Flag value for the next cycle
  output wire next_flag_o
);

  // History starts at the idle level so reset makes no false edge
  reg  pin_q;
  reg  next_flag;
  wire fall = pin_q & ~pin_n_i;

  always @*
  begin
    next_flag = flag_i;
    if (sw_write_i)
      next_flag = sw_value_i;
    if (hw_clear_i)
      next_flag = 1'b0;
    // Level mode follows the pin; in edge mode a set beats any clear
    if (!edge_mode_i)
      next_flag = ~pin_n_i;
    else if (fall)
      next_flag = 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      pin_q <= IDLE_LEVEL;
    else if (ce_i)
      pin_q <= pin_n_i;
  end

  assign next_flag_o = next_flag;
endmodule
`default_nettype wire

/* File: test/pic_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_monitor
(
  // Clock, reset and bus
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i, dat_o,
  // Core side
  input wire logic vector_ack_i, irq_req_o,
  input wire logic [2:0] irq_index_o,
  input wire logic [1:0] irq_level_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic [7:0] irq_taken_o
);
  logic ga;
  wire take = irq_req_o && vector_ack_i;
  // Taken at the ack edge, so it lags the stored bit by one cycle
  always @(posedge clk_i)
    if (rst_i) ga <= 1'b0;
    else if (ack_o && we_i && sel_i[0] && adr_i[9:2] == 8'ha8) ga <= dat_i[7];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper bits set");
  a_vec_map: assert property (irq_req_o |->
    irq_vector_o == 16'h0003 + {10'h0, irq_index_o, 3'h0}) else $error("vec");
  a_take_drop: assert property (take |=> !irq_req_o)
    else $error("req held");
  a_take_hot: assert property (take |=>
    irq_taken_o == 8'h01 << $past(irq_index_o)) else $error("taken bad");
  a_taken_why: assert property (irq_taken_o != 8'h0 |-> $past(take))
    else $error("stray take");
  a_global_gate: assert property (!ga |-> !irq_req_o)
    else $error("req while off");
  cover property (take);
  cover property (ack_o && we_i);
  cover property (irq_req_o && irq_level_o == 2'h3);
endmodule
bind priority_interrupt_controller pic_monitor mon (.*);
`default_nettype wire

/* File: test/core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module core_model
(
  input  wire logic clk_i, rst_i, take_i, slow_i, req_i,
  output var  logic ack_o
);
  logic seen;
  // Slow core lets the request stand one extra cycle
  always @(posedge clk_i)
    if (rst_i || !req_i || ack_o || !take_i)
      {seen, ack_o} <= 2'b00;
    else
      {seen, ack_o} <= {1'b1, !slow_i || seen};
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, rt = 0;
  logic p2 = 1, p3 = 1, take = 0, slow = 0, ack_o, req, vack;
  logic [9:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [5:0] fl = 0;
  logic [31:0] dat_i = 0, rd, dat_o;
  logic [2:0] idx;
  logic [1:0] lvl;
  logic [15:0] vec;
  logic [7:0] tkn;
  int failures = 0, n_checks = 0;
  priority_interrupt_controller DUT (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .ext0_flag_i(fl[0]), .timer0_flag_i(fl[1]), .ext1_flag_i(fl[2]),
    .timer1_flag_i(fl[3]), .uart_flag_i(fl[4]), .timer2_flag_i(fl[5]),
    .ext2_pin_n_i(p2), .ext3_pin_n_i(p3), .vector_ack_i(vack),
    .isr_return_i(rt), .irq_req_o(req), .irq_index_o(idx),
    .irq_level_o(lvl), .irq_vector_o(vec), .irq_taken_o(tkn));
  core_model core (.clk_i, .rst_i, .take_i(take), .slow_i(slow),
    .req_i(req), .ack_o(vack));
  always #50 clk_i = ~clk_i;
  initial begin #100000; failures++; wrap_up; end
  task automatic wt(input int n); repeat (n) @(posedge clk_i); endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {a, 2'b00};
    sel_i <= 4'h1; dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o; cyc_i <= 0; stb_i <= 0; @(posedge clk_i);
  endtask
  task automatic grab(input logic [7:0] e);
    int k = 0;
    take <= 1;
    do @(posedge clk_i); while (tkn !== e && ++k < 20);
    take <= 0; `CHK(tkn, e)
  endtask
  task automatic ret; rt <= 1; @(posedge clk_i); rt <= 0; endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'ha8, 8'hb7, 8'hb8, 8'h10, 8'hc0};
    logic [7:0] e [5] = '{8'hbf, 8'hff, 8'h3f, 8'h00, 8'h00};
    foreach (a[i])
    begin
      bus(0, a[i], 0); `CHK(rd, 32'h0)
      bus(1, a[i], i < 4 ? 8'hff : 8'h00); bus(0, a[i], 0);
      `CHK(rd, {24'h0, e[i]})
      bus(1, a[i], 0);
    end
    $display("t_regs done");
  endtask
  task automatic t_gate;
    fl <= 6'h3f; bus(1, 8'ha8, 8'h3f); wt(3);
    `CHK(req, 1'b0)
    for (int i = 0; i < 6; i++)
    begin
      bus(1, 8'ha8, 8'h80 | 8'h01 << i); wt(2);
      `CHK({req, idx}, {1'b1, 3'(i)})
    end
    $display("t_gate done");
  endtask
  task automatic t_prio;
    bus(1, 8'ha8, 8'hbf); wt(2);
    `CHK({idx, lvl}, 5'h00)
    bus(1, 8'hb8, 8'h20); bus(1, 8'hb7, 8'h28); wt(2);
    `CHK({idx, lvl}, 5'h17)
    slow <= 1; grab(8'h20); slow <= 0; fl <= 6'h1f; wt(3);
    `CHK(req, 1'b0)
    ret; wt(3);
    `CHK({req, idx, lvl}, 6'h2e)
    grab(8'h08); fl <= 6'h3f; wt(3);
    `CHK({req, idx, lvl}, 6'h37)
    rst_i <= 1; fl <= 0; wt(2); rst_i <= 0;
    $display("t_prio done");
  endtask
  task automatic t_ext;
    bus(1, 8'ha8, 8'h80); bus(1, 8'hc0, 8'h05); p2 <= 0; wt(4);
    `CHK({req, idx}, 4'he)
    bus(0, 8'hc0, 0); `CHK(rd, 32'h07)
    grab(8'h40); bus(0, 8'hc0, 0); `CHK(rd, 32'h05)
    ret; p2 <= 1; bus(1, 8'hc0, 8'hc0); p3 <= 0; wt(4);
    `CHK({req, idx, lvl}, 6'h3d)
    grab(8'h80); bus(0, 8'hc0, 0); `CHK(rd, 32'he0)
    bus(0, 8'hd0, 0); `CHK(rd, 32'h02)
    bus(0, 8'hd4, 0); `CHK(rd, 32'h3d)
    p3 <= 1; bus(1, 8'hd0, 8'h01); wt(2);
    bus(0, 8'hc0, 0); `CHK(rd, 32'hc0)
    bus(0, 8'hd0, 0); `CHK(rd, 32'h00)
    $display("t_ext done");
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    wt(8);
    rst_i <= 0;
    t_regs; t_gate; t_prio; t_ext;
    wrap_up;
  end
endmodule
`default_nettype wire
